// file: pin_ctrl_pkg.sv
`default_nettype none
package pin_ctrl_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_P5_CTRL = 4'h0;
   localparam logic [3:0] OFF_P6_CTRL = 4'h4;
   localparam logic [3:0] OFF_P7_CTRL = 4'h8;
   localparam logic [3:0] OFF_P8_CTRL = 4'hC;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_DIR  = 8'hFF;  // all pins high impedance
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_TONE = 8'hC0;  // keytone powered off
   localparam logic [7:0] RST_KS   = 8'hFF;  // no key seen

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int B_P8L = 0;
   localparam int B_P8H = 1;
   localparam int B_P9L = 2;
   localparam int B_P9H = 3;
   localparam int B_CWP = 4;
   localparam int B_DAS = 4;
   localparam int B_TONE_SW = 5;
   localparam int B_DEN = 7;
   localparam int B_PB_SEG = 5;
   localparam int B_PCL = 6;
   localparam int B_PCH = 7;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS        = 50;
   localparam int INSTR_NS      = 100;
   localparam int STROBE_CYCLES = (INSTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_SEGS   = 16;
   localparam logic [3:0] HALF_DIV32 = 4'hF;  // toggle count minus one
   localparam logic [3:0] HALF_DIV16 = 4'h7;
   localparam logic [3:0] HALF_DIV8  = 4'h3;
   localparam logic [1:0] KT_OFF     = 2'h3;

   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_DEC = 2'h3;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {IDLE, RUN} phase_t;
   typedef struct packed {logic [7:0] out; logic [7:0] oe;} pad_t;
   typedef struct packed {pad_t p6, p7, p8, p9, pb, pc;
                          logic [1:0] p5_out, p5_oe;} pads_t;
   typedef struct packed {logic [1:0] p5; logic [7:0] p6, p7, p8, p9, pb, pc;} gpio_t;
   typedef struct packed {logic [7:0] p9, pb, pc;} dir_t;

endpackage
`default_nettype wire

// file: pin_ctrl.sv
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl
   import pin_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic      [1:0]  response,
   output logic             waitrequest,
   input  wire logic [1:0]  page_sel,
   input  wire logic        strobe_start,
   input  wire logic [3:0]  key_pins,
   input  wire logic        clk32k_pin,
   input  wire gpio_t       port_data,
   input  wire dir_t        port_dir,
   input  wire logic [79:48] seg_in,
   output pads_t            pads,
   output logic [15:0]      strobe_low,
   output logic             strobe_busy,
   output logic             strobe_done,
   output logic             key_tone,
   output logic [6:0]       dac_code,
   output logic             dac_enable,
   output logic [2:0]       dac_level,
   output logic             dac_pin_active,
   output logic [3:0]       lcd_bias_code,
   output logic [1:0]       lcd_drive_strength,
   output logic             call_waiting_power
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] p5c;   // port5 dir and pin switch
      logic [7:0] tone;  // tone, dac switch, bias
      logic [7:0] p6d;
      logic [7:0] dac;
      logic [7:0] psw;   // pin switch, lcd drive
      logic [7:0] p7d;
      logic [7:0] ks_lo;
      logic [7:0] p8d;
      logic [7:0] ks_hi;
      logic       ack;
      logic [7:0] rdata;
      logic [1:0] resp;
      logic [3:0] k_s1;
      logic [3:0] k_s2;
      logic       c_s1;
      logic       c_s2;
      logic       c_d;
      phase_t     ph;
      logic [3:0] seg;
      logic [1:0] cyc;
      logic       done;
      logic [3:0] tcnt;
      logic       tone_q;
      logic       chk_pend;  // slot waiting for its key verdict
      logic [3:0] chk_seg;
   } st_t;

   st_t s;
   st_t next_s;
   logic [15:0] ks_all;
   logic [3:0]  sel;
   logic        tick;

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   // index of register, 4'hF when unmapped
   function automatic logic [3:0] reg_sel(input logic [3:0] a, input logic [1:0] pg);
      logic [3:0] r;
      r = 4'hF;
      if (a == OFF_P5_CTRL && pg <= 2'h1) r = {3'h0, pg[0]};
      if (a == OFF_P6_CTRL && pg <= 2'h2) r = 4'h2 + {2'h0, pg};
      if (a == OFF_P7_CTRL && pg <= 2'h1) r = 4'h5 + {3'h0, pg[0]};
      if (a == OFF_P8_CTRL && pg <= 2'h1) r = 4'h7 + {3'h0, pg[0]};
      return r;
   endfunction

   // {oe,out} of a nibble shared with a segment group
   function automatic logic [7:0] nib(input logic sw, input logic [3:0] sg,
                                      input logic [3:0] d, input logic [3:0] dir);
      return sw ? {4'hF, sg} : {~dir, d};
   endfunction

   function automatic logic [3:0] half(input logic [1:0] kt);
      logic [3:0] h;
      h = HALF_DIV32;
      if (kt == 2'h1) h = HALF_DIV16;
      if (kt == 2'h2) h = HALF_DIV8;
      return h;
   endfunction

   assign sel    = reg_sel(address, page_sel);
   assign ks_all = {s.ks_hi, s.ks_lo};
   assign tick   = s.c_s2 & ~s.c_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] rv;
      logic [7:0] wd;
      rv = 8'h00;
      wd = writedata[7:0];
      next_s = s;
      next_s.done = 1'b0;
      next_s.chk_pend = 1'b0;
      next_s.k_s1 = key_pins;
      next_s.k_s2 = s.k_s1;
      next_s.c_s1 = clk32k_pin;
      next_s.c_s2 = s.c_s1;
      next_s.c_d  = s.c_s2;
      // bus: one wait cycle, answer on the second
      next_s.ack = (read | write) & ~s.ack;
      unique case (sel)
         4'h0: rv = s.p5c;
         4'h1: rv = s.tone;
         4'h2: rv = s.p6d;
         4'h3: rv = s.dac;
         4'h4: rv = s.psw;
         4'h5: rv = s.p7d;
         4'h6: rv = s.ks_lo;
         4'h7: rv = s.p8d;
         4'h8: rv = s.ks_hi;
         default: rv = 8'h00;
      endcase
      if ((read | write) && !s.ack) begin
         next_s.rdata = read ? rv : 8'h00;
         next_s.resp  = (sel == 4'hF) ? RESP_DEC : RESP_OK;
      end
      // register write at the answering edge
      if (write && s.ack) begin
         unique case (sel)
            4'h0: next_s.p5c   = wd;
            4'h1: next_s.tone  = wd;
            4'h2: next_s.p6d   = wd;
            4'h3: next_s.dac   = wd;
            4'h4: next_s.psw   = wd;
            4'h5: next_s.p7d   = wd;
            4'h6: next_s.ks_lo = wd;
            4'h7: next_s.p8d   = wd;
            4'h8: next_s.ks_hi = wd;
            default: ;
         endcase
      end
      // key strobe sequencer, one instruction per segment
      unique case (s.ph)
         IDLE: begin
            if (strobe_start) begin
               next_s.ph  = RUN;
               next_s.seg = 4'h0;
               next_s.cyc = 2'h0;
            end
         end
         RUN: begin
            next_s.cyc = s.cyc + 2'h1;
            if (s.cyc == 2'(STROBE_CYCLES - 1)) begin
               next_s.cyc = 2'h0;
               // slot over: its key rows reach the second flop next cycle
               next_s.chk_pend = 1'b1;
               next_s.chk_seg  = s.seg;
               next_s.seg = s.seg + 4'h1;
               if (s.seg == 4'(STROBE_SEGS - 1)) begin
                  next_s.ph   = IDLE;
                  next_s.done = 1'b1;
               end
            end
         end
      endcase
      // rows seen during the slot just ended: latch zero there,
      // placed after the register write so the hardware clear wins
      if (s.chk_pend && s.k_s2 != 4'hF) begin
         if (s.chk_seg[3]) begin
            next_s.ks_hi[s.chk_seg[2:0]] = 1'b0;
         end else begin
            next_s.ks_lo[s.chk_seg[2:0]] = 1'b0;
         end
      end
      // keytone divider on 32.768 kHz ticks
      if (s.tone[7:6] == KT_OFF) begin
         next_s.tcnt   = 4'h0;
         next_s.tone_q = 1'b0;
      end else if (tick) begin
         if (s.tcnt >= half(s.tone[7:6])) begin
            next_s.tcnt   = 4'h0;
            next_s.tone_q = ~s.tone_q;
         end else begin
            next_s.tcnt = s.tcnt + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s       <= '0;
         s.p5c   <= RST_DIR & 8'h60;
         s.tone  <= RST_TONE;
         s.p6d   <= RST_DIR;
         s.dac   <= RST_CTRL;
         s.psw   <= RST_CTRL;
         s.p7d   <= RST_DIR;
         s.ks_lo <= RST_KS;
         s.p8d   <= RST_DIR;
         s.ks_hi <= RST_KS;
         s.k_s1  <= 4'hF;
         s.k_s2  <= 4'hF;
         s.ph    <= IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // bus answers
   // ------------------------------------------------------------
   assign waitrequest = (read | write) & ~s.ack;
   assign readdata    = {24'h000000, s.rdata};
   assign response    = s.resp;

   // ------------------------------------------------------------
   // pin routing
   // ------------------------------------------------------------
   always_comb begin
      pads = '0;
      pads.p5_out = port_data.p5;
      pads.p5_oe  = ~s.p5c[6:5];
      {pads.p8.oe[3:0], pads.p8.out[3:0]} =
         nib(s.p5c[B_P8L], seg_in[67:64], port_data.p8[3:0], s.p8d[3:0]);
      {pads.p8.oe[7:4], pads.p8.out[7:4]} =
         nib(s.p5c[B_P8H], seg_in[71:68], port_data.p8[7:4], s.p8d[7:4]);
      {pads.p9.oe[3:0], pads.p9.out[3:0]} =
         nib(s.p5c[B_P9L], seg_in[75:72], port_data.p9[3:0], port_dir.p9[3:0]);
      {pads.p9.oe[7:4], pads.p9.out[7:4]} =
         nib(s.p5c[B_P9H], seg_in[79:76], port_data.p9[7:4], port_dir.p9[7:4]);
      {pads.pb.oe[3:0], pads.pb.out[3:0]} =
         nib(s.psw[B_PB_SEG], seg_in[51:48], port_data.pb[3:0], port_dir.pb[3:0]);
      {pads.pb.oe[7:4], pads.pb.out[7:4]} =
         nib(s.psw[B_PB_SEG], seg_in[55:52], port_data.pb[7:4], port_dir.pb[7:4]);
      {pads.pc.oe[3:0], pads.pc.out[3:0]} =
         nib(s.psw[B_PCL], seg_in[59:56], port_data.pc[3:0], port_dir.pc[3:0]);
      {pads.pc.oe[7:4], pads.pc.out[7:4]} =
         nib(s.psw[B_PCH], seg_in[63:60], port_data.pc[7:4], port_dir.pc[7:4]);
      pads.p7.out = port_data.p7;
      pads.p7.oe  = ~s.p7d;
      pads.p6.out = port_data.p6;
      pads.p6.oe  = ~s.p6d;
      // analog dac output: digital driver released
      if (s.tone[B_DAS]) begin
         pads.p6.out[6] = 1'b0;
         pads.p6.oe[6]  = 1'b0;
      end
      if (s.tone[B_TONE_SW]) begin
         pads.p6.out[7] = s.tone_q;
         pads.p6.oe[7]  = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------
   assign key_tone           = s.tone_q;
   assign dac_pin_active     = s.tone[B_DAS];
   assign dac_code           = s.dac[6:0];
   assign dac_enable         = s.dac[B_DEN];
   assign dac_level          = s.psw[2:0];
   assign lcd_drive_strength = s.psw[4:3];
   assign lcd_bias_code      = s.tone[3:0];
   assign call_waiting_power = s.p5c[B_CWP];
   assign strobe_busy        = (s.ph == RUN);
   assign strobe_low         = strobe_busy ? ~(16'h0001 << s.seg) : 16'hFFFF;
   assign strobe_done        = s.done;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_bus_answer: assert property ((read || write) && !s.ack |=> !waitrequest)
      else $error("bus answer late");
   a_page_write: assert property (
      write && !waitrequest && address == OFF_P5_CTRL && page_sel == 2'h1
      |=> s.tone == $past(writedata[7:0]))
      else $error("page write lost");
   a_unmapped_err: assert property (
      (read || write) && !s.ack && page_sel == 2'h3 |=> response == RESP_DEC)
      else $error("unmapped not refused");
   a_p8_low_seg: assert property (
      s.p5c[B_P8L] |-> pads.p8.oe[3:0] == 4'hF && pads.p8.out[3:0] == seg_in[67:64])
      else $error("port8 low not segment");
   a_p6_dir_map: assert property (
      !s.tone[B_DAS] && !s.tone[B_TONE_SW] |-> pads.p6.oe == ~s.p6d)
      else $error("port6 direction wrong");
   a_dac_route: assert property (s.tone[B_DAS] |-> !pads.p6.oe[6] && dac_pin_active)
      else $error("dac pin still driven");
   a_tone_off: assert property (s.tone[7:6] == KT_OFF |=> !key_tone)
      else $error("keytone not off");
   a_strobe_len: assert property (
      $rose(strobe_busy) |-> strobe_busy[*8] ##25 !strobe_busy ##0 strobe_done)
      else $error("strobe length wrong");
   a_strobe_clear: assert property (
      s.chk_pend && s.k_s2 != 4'hF |=> !ks_all[$past(s.chk_seg)])
      else $error("strobe bit not cleared");
   a_strobe_idle: assert property (!strobe_busy |-> strobe_low == 16'hFFFF)
      else $error("strobe line low while idle");

endmodule
`default_nettype wire

// file: pin_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module pin_far_side_model (
   input  wire logic [15:0] strobe_low,
   input  wire logic [4:0]  press_slot,
   output logic [3:0]       key_pins,
   output logic             clk32k_pin,
   output int               tick_count
);
   // ------------------------------------------------------------
   // key matrix and crystal
   // ------------------------------------------------------------
   // pulled-up rows; the pressed key ties row 2 to its own segment line
   // slot number zero means no key pressed
   always_comb begin
      key_pins = 4'hF;
      if (press_slot != 5'h00 && strobe_low[press_slot[3:0]] === 1'b0) begin
         key_pins[2] = 1'b0;
      end
   end

   // free-running 32.768 kHz source, rising edges counted
   initial begin
      clk32k_pin = 1'b0;
      tick_count = 0;
      forever begin
         #15259;
         clk32k_pin = ~clk32k_pin;
         tick_count = tick_count + int'(clk32k_pin);
      end
   end
endmodule
`default_nettype wire

// file: tb_io_pin_switch_control_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_io_pin_switch_control_bank
   import pin_ctrl_pkg::*;
;
   typedef struct packed {logic [3:0] a; logic [1:0] pg; logic [7:0] wd, rd;
                          logic [1:0] rs; logic [18:0] f;} row_t;
   localparam row_t ROWS [14] = '{
      '{4'h0, 2'h0, 8'h70, 8'h70, 2'h0, 19'h40000}, '{4'h0, 2'h1, 8'hDF, 8'hDF, 2'h0, 19'h7E000},
      '{4'h4, 2'h1, 8'hFF, 8'hFF, 2'h0, 19'h7FFE0}, '{4'h4, 2'h2, 8'h1D, 8'h1D, 2'h0, 19'h7FFF7},
      '{4'h4, 2'h1, 8'h2A, 8'h2A, 2'h0, 19'h7E557}, '{4'h0, 2'h1, 8'hC0, 8'hC0, 2'h0, 19'h40557},
      '{4'h0, 2'h0, 8'h60, 8'h60, 2'h0, 19'h00557}, '{4'h4, 2'h2, 8'h08, 8'h08, 2'h0, 19'h00541},
      '{4'h4, 2'h2, 8'h10, 8'h10, 2'h0, 19'h00542}, '{4'h8, 2'h1, 8'h5A, 8'h5A, 2'h0, 19'h00542},
      '{4'hC, 2'h1, 8'hA5, 8'hA5, 2'h0, 19'h00542}, '{4'h0, 2'h2, 8'h33, 8'h00, 2'h3, 19'h00542},
      '{4'h4, 2'h3, 8'h33, 8'h00, 2'h3, 19'h00542}, '{4'h2, 2'h0, 8'h33, 8'h00, 2'h3, 19'h00542}};

   logic        clk, nrst, read, write, waitrequest, strobe_start, clk32k_pin, key_tone;
   logic        strobe_busy, strobe_done, dac_enable, dac_pin_active, call_waiting_power;
   logic [3:0]  address, key_pins, lcd_bias_code;
   logic [1:0]  page_sel, response, lcd_drive_strength, rs;
   logic [31:0] writedata, readdata, rd;
   logic [6:0]  dac_code;
   logic [2:0]  dac_level;
   logic [15:0] strobe_low;
   logic [4:0]  press_slot;
   logic [79:48] seg_in;
   logic [18:0] fields;
   logic [7:0]  c5, sw;
   gpio_t       port_data;
   dir_t        port_dir;
   pads_t       pads;
   int          miscompares, cmp_count, tick_count, t0;

   assign fields = {call_waiting_power, lcd_bias_code, dac_pin_active, dac_enable, dac_code,
                    dac_level, lcd_drive_strength};

   pin_ctrl dut (.clk, .nrst, .address, .read, .write, .writedata, .readdata, .response,
                 .waitrequest, .page_sel, .strobe_start, .key_pins, .clk32k_pin, .port_data,
                 .port_dir, .seg_in, .pads, .strobe_low, .strobe_busy, .strobe_done, .key_tone,
                 .dac_code, .dac_enable, .dac_level, .dac_pin_active, .lcd_bias_code,
                 .lcd_drive_strength, .call_waiting_power);
   pin_far_side_model far (.strobe_low, .press_slot, .key_pins, .clk32k_pin, .tick_count);

   always #25 clk = ~clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [1:0] pg,
                      input logic [7:0] d);
      int n;
      @(posedge clk);
      address <= a;
      page_sel <= pg;
      writedata <= {24'h0, d};
      read <= ~wr;
      write <= wr;
      // waitrequest and read data taken at the same rising edge
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (!waitrequest) break;
      end
      if (n == 20) begin
         miscompares++;
         finish_test();
      end
      rd = readdata;
      rs = response;
      read <= 1'b0;
      write <= 1'b0;
      // let the accepted write settle before the pins are looked at
      @(negedge clk);
   endtask

   function automatic pad_t mx(input logic lo, input logic hi, input logic [7:0] s,
                               input logic [7:0] d, input logic [7:0] dir);
      logic [7:0] m;
      m = {{4{hi}}, {4{lo}}};
      mx.out = (s & m) | (d & ~m);
      mx.oe = m | ~dir;
   endfunction

   // one key strobe with a refused restart in mid-run
   task automatic strobe(input logic [4:0] slot);
      int n, i;
      n = 0;
      @(posedge clk);
      press_slot <= slot;
      strobe_start <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge clk);
         strobe_start <= (n == 3);
         @(negedge clk);
         if (strobe_done) break;
         n += int'(strobe_busy);
      end
      if (i == 60) begin
         miscompares++;
         finish_test();
      end
      chk("busy cycles", 32, n);
      @(negedge clk);
      chk("done pulse", 0, strobe_done);
   endtask

   // ticks between two keytone edges
   task automatic tone(input logic [1:0] kt);
      int i;
      logic v;
      bus(1'b1, 4'h0, 2'h1, {kt, 6'h30});
      for (int k = 0; k < 2; k++) begin
         v = key_tone;
         for (i = 0; i < 25000 && key_tone === v; i++) @(negedge clk);
         if (i == 25000) begin
            miscompares++;
            finish_test();
         end
         if (k == 0) t0 = tick_count;
      end
      chk("tone ticks", 4 << (2 - kt), tick_count - t0);
      chk("tone pin", key_tone, pads.p6.out[7]);
      $display("test tone %0d done", kt);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {read, write, strobe_start, address, page_sel, writedata, press_slot} = '0;
      seg_in = 32'hC3A5_5A3C;
      port_data = 50'h2_1357_9BDF_2468;
      port_dir = 24'h0FF03C;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      foreach (ROWS[i]) begin
         bus(1'b1, ROWS[i].a, ROWS[i].pg, ROWS[i].wd);
         bus(1'b0, ROWS[i].a, ROWS[i].pg, 8'h00);
         chk("readdata", ROWS[i].rd, rd);
         chk("response", ROWS[i].rs, rs);
         chk("fields", ROWS[i].f, fields);
      end
      $display("test register rows done");
      for (int i = 0; i < 7; i++) begin
         c5 = (i < 4) ? (8'h60 | (8'h1 << i)) : 8'h60;
         sw = (i < 4) ? 8'h00 : (8'h1 << (i + 1));
         bus(1'b1, 4'h0, 2'h0, c5);
         bus(1'b1, 4'h4, 2'h2, sw);
         @(negedge clk);
         chk("p8", mx(c5[0], c5[1], seg_in[71:64], port_data.p8, 8'hFF), pads.p8);
         chk("p9", mx(c5[2], c5[3], seg_in[79:72], port_data.p9, port_dir.p9), pads.p9);
         chk("pb", mx(sw[5], sw[5], seg_in[55:48], port_data.pb, port_dir.pb), pads.pb);
         chk("pc", mx(sw[6], sw[7], seg_in[63:56], port_data.pc, port_dir.pc), pads.pc);
      end
      $display("test pin switch done");
      bus(1'b1, 4'h4, 2'h0, 8'h3C);
      bus(1'b1, 4'h8, 2'h0, 8'hC3);
      bus(1'b1, 4'hC, 2'h0, 8'h0F);
      bus(1'b1, 4'h0, 2'h0, 8'h20);
      chk("p6 oe", 8'hC3, pads.p6.oe);
      chk("p7 oe", 8'h3C, pads.p7.oe);
      chk("p8 oe", 8'hF0, pads.p8.oe);
      chk("p5 oe", 2'b10, pads.p5_oe);
      $display("test direction done");
      tone(2'h2);
      chk("p6 shared oe", 2'b10, pads.p6.oe[7:6]);
      chk("dac pin", 1, dac_pin_active);
      tone(2'h1);
      tone(2'h0);
      bus(1'b1, 4'h0, 2'h1, 8'hF0);
      repeat (3000) @(negedge clk);
      chk("tone off", 0, key_tone);
      bus(1'b1, 4'h8, 2'h1, 8'hFF);
      bus(1'b1, 4'hC, 2'h1, 8'hFF);
      strobe(5'd1);
      strobe(5'd9);
      bus(1'b0, 4'h8, 2'h1, 8'h00);
      chk("strobe low reg", 8'hFD, rd);
      bus(1'b0, 4'hC, 2'h1, 8'h00);
      chk("strobe high reg", 8'hFD, rd);
      $display("test key strobe done");
      @(posedge clk);
      strobe_start <= 1'b1;
      @(posedge clk);
      strobe_start <= 1'b0;
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk("busy after reset", 0, strobe_busy);
      chk("p5 oe reset", 0, pads.p5_oe);
      bus(1'b0, 4'h0, 2'h1, 8'h00);
      chk("tone reset", 8'hC0, rd);
      bus(1'b0, 4'hC, 2'h1, 8'h00);
      chk("strobe reset", 8'hFF, rd);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
`default_nettype wire
